// ==== mmt_timer_ab.sv ====
`timescale 1ns/1ps
module mmt_timer_ab (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic nmiN,
	input wire logic [4:0] taIn,
	input wire logic [5:0] tbIn,
	output logic [4:0] taOut,
	output logic [4:0] taOutEn
);
	mmt_pkg::mmt_state_t q;
	mmt_pkg::mmt_state_t next_q;
	logic wrEn;
	logic rdEn;
	logic [9:0] wordAddr;
	logic [31:0] rdVal;
	logic rdRel;
	logic [4:0] aRel;
	logic [4:0] aOvf;
	logic [4:0] aTk;
	logic [5:0] bRel;
	logic [5:0] bEff;
	logic [5:0] bTk;
	logic [4:0] setA;
	logic [5:0] setB;
	logic [4:0] swTrig;
	logic [5:0] bRun;
	logic [5:0] bOvf;

	// count source tick from the free prescaler
	function automatic logic srcTick(input logic [1:0] sel,
		input logic [5:0] pre);
		unique case (sel)
			2'h0: srcTick = 1'b1;
			2'h1: srcTick = (pre[2:0] == 3'h0);
			2'h2: srcTick = (pre[4:0] == 5'h00);
			2'h3: srcTick = (pre == 6'h00);
		endcase
	endfunction : srcTick

	// byte-lane merge of a write into a 32-bit view
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int k = 0; k < 4; k++) begin
			if (be[k]) begin
				r[8*k +: 8] = wd[8*k +: 8];
			end
		end
		merge = r;
	endfunction : merge

	// byte offset of a timer's sub-register
	function automatic logic [9:0] tOff(input int base, input int idx,
		input int sub);
		tOff = 10'(base + idx * mmt_pkg::TMR_STRIDE + sub);
	endfunction : tOff

	// one-cycle bus handshake
	assign waitrequest = (read | write) & ~q.ack;
	assign readdata = q.rdata;
	assign wordAddr = {address[9:2], 2'b00};

	// pin outputs from flops, cutoff with nmi low floats timers 1, 2 and 4
	always_comb begin
		for (int i = 0; i < mmt_pkg::NUM_A; i++) begin
			taOut[i] = q.ta[i].out;
			taOutEn[i] = 1'b1;
			if ((i == 1 || i == 2 || i == 4) && q.cutoff && !q.nmiS2) begin
				taOutEn[i] = 1'b0;
			end
		end
	end

	// whole next state
	always_comb begin
		logic [31:0] wd;
		logic [31:0] old;
		logic st;
		logic edg;
		logic anyEdg;
		logic [1:0] md;
		wd = 32'h0000_0000;
		old = 32'h0000_0000;
		st = 1'b0;
		edg = 1'b0;
		anyEdg = 1'b0;
		md = 2'h0;
		next_q = q;
		wrEn = write & ~q.ack;
		rdEn = read & ~q.ack;
		next_q.ack = (read | write) & ~q.ack;
		next_q.nmiS1 = nmiN;
		next_q.nmiS2 = q.nmiS1;
		next_q.pre = q.pre + 6'h01;
		aRel = '0;
		aOvf = '0;
		aTk = '0;
		bRel = '0;
		bEff = '0;
		bTk = '0;
		setA = '0;
		setB = '0;
		swTrig = '0;
		bRun = '0;
		bOvf = '0;
		if (wrEn && wordAddr == mmt_pkg::OFF_ONE_SHOT && byteenable[0]) begin
			swTrig = writedata[4:0];
		end
		// first family
		for (int i = 0; i < mmt_pkg::NUM_A; i++) begin
			st = q.startA[i];
			md = q.ta[i].mode[1:0];
			next_q.ta[i].inS1 = taIn[i];
			next_q.ta[i].inS2 = q.ta[i].inS1;
			next_q.ta[i].inPrev = q.ta[i].inS2;
			edg = q.ta[i].inS2 & ~q.ta[i].inPrev;
			aTk[i] = srcTick(q.ta[i].mode[7:6], q.pre);
			next_q.ta[i].stPrev = st;
			next_q.ta[i].stopIr = 1'b0;
			if (q.ta[i].stopIr) begin
				setA[i] = 1'b1;
			end
			unique case (md)
				mmt_pkg::AM_TIMER: begin
					if (st && aTk[i]) begin
						if (q.ta[i].cnt == mmt_pkg::CNT_ZERO) begin
							next_q.ta[i].cnt = q.ta[i].rld;
							aRel[i] = 1'b1;
							setA[i] = 1'b1;
							if (q.ta[i].mode[mmt_pkg::MODE_OUT_EN]) begin
								next_q.ta[i].out = ~q.ta[i].out;
							end
						end else begin
							next_q.ta[i].cnt = q.ta[i].cnt - 16'h0001;
						end
					end
				end
				mmt_pkg::AM_EVENT: begin
					if (st && edg) begin
						if (q.ta[i].mode[mmt_pkg::MODE_UP]) begin
							if (q.ta[i].cnt == mmt_pkg::CNT_ALL1) begin
								next_q.ta[i].cnt = q.ta[i].rld;
								aRel[i] = 1'b1;
								aOvf[i] = 1'b1;
								setA[i] = 1'b1;
							end else begin
								next_q.ta[i].cnt = q.ta[i].cnt + 16'h0001;
							end
						end else if (q.ta[i].cnt == mmt_pkg::CNT_ZERO) begin
							next_q.ta[i].cnt = q.ta[i].rld;
							aRel[i] = 1'b1;
							setA[i] = 1'b1;
						end else begin
							next_q.ta[i].cnt = q.ta[i].cnt - 16'h0001;
						end
					end
				end
				mmt_pkg::AM_ONESHOT: begin
					if (!st && q.ta[i].stPrev) begin
						next_q.ta[i].cnt = q.ta[i].rld;
						next_q.ta[i].out = 1'b0;
						next_q.ta[i].run = 1'b0;
						next_q.ta[i].trig = 1'b0;
						next_q.ta[i].retrig = 1'b0;
						next_q.ta[i].stopIr = 1'b1;
					end else if (st) begin
						// trigger waits for the next source tick
						if (q.ta[i].mode[mmt_pkg::MODE_EXT_TRIG] ? edg
							: swTrig[i]) begin
							if (q.ta[i].run) begin
								next_q.ta[i].retrig = 1'b1;
							end else begin
								next_q.ta[i].trig = 1'b1;
							end
						end
						if (aTk[i]) begin
							if (q.ta[i].trig) begin
								next_q.ta[i].trig = 1'b0;
								next_q.ta[i].run = 1'b1;
								next_q.ta[i].out = 1'b1;
							end else if (q.ta[i].run && q.ta[i].retrig) begin
								next_q.ta[i].retrig = 1'b0;
								next_q.ta[i].cnt = q.ta[i].rld;
								aRel[i] = 1'b1;
							end else if (q.ta[i].run) begin
								if (q.ta[i].cnt == mmt_pkg::CNT_ZERO) begin
									next_q.ta[i].cnt = q.ta[i].rld;
									next_q.ta[i].out = 1'b0;
									next_q.ta[i].run = 1'b0;
									aRel[i] = 1'b1;
									setA[i] = 1'b1;
								end else begin
									next_q.ta[i].cnt = q.ta[i].cnt - 16'h0001;
								end
							end
						end
					end
				end
				mmt_pkg::AM_PWM: begin
					if (!st && q.ta[i].stPrev) begin
						if (q.ta[i].out) begin
							next_q.ta[i].out = 1'b0;
							setA[i] = 1'b1;
						end
					end else if (st && !q.ta[i].stPrev) begin
						next_q.ta[i].cnt = mmt_pkg::CNT_ZERO;
						next_q.ta[i].out = 1'b0;
					end else if (st && aTk[i]) begin
						if (q.ta[i].cnt == mmt_pkg::CNT_ZERO) begin
							aRel[i] = 1'b1;
							next_q.ta[i].out = ~q.ta[i].out;
							if (q.ta[i].out) begin
								next_q.ta[i].cnt = ~q.ta[i].rld;
								setA[i] = 1'b1;
							end else begin
								next_q.ta[i].cnt = q.ta[i].rld;
							end
						end else begin
							next_q.ta[i].cnt = q.ta[i].cnt - 16'h0001;
						end
					end
				end
			endcase
		end
		// second family
		for (int i = 0; i < mmt_pkg::NUM_B; i++) begin
			st = (i < 3) ? q.startA[mmt_pkg::START_B_LSB + i]
				: q.startB[mmt_pkg::START_B_LSB + i - 3];
			bRun[i] = st;
			md = q.tb[i].mode[1:0];
			next_q.tb[i].inS1 = tbIn[i];
			next_q.tb[i].inS2 = q.tb[i].inS1;
			next_q.tb[i].inPrev = q.tb[i].inS2;
			edg = q.tb[i].inS2 & ~q.tb[i].inPrev;
			anyEdg = q.tb[i].inS2 ^ q.tb[i].inPrev;
			bTk[i] = srcTick(q.tb[i].mode[7:6], q.pre);
			next_q.tb[i].stPrev = st;
			if (st && !q.tb[i].stPrev) begin
				next_q.tb[i].first = 1'b1;
			end
			if (md == mmt_pkg::BM_MEASURE) begin
				// width mode takes both edges, results alternate
				bEff[i] = st & (q.tb[i].mode[mmt_pkg::MODE_WIDTH_SEL]
					? anyEdg : edg);
				if (bEff[i]) begin
					// counter is not cleared at start: first result is junk
					next_q.tb[i].rld = ~q.tb[i].cnt;
					next_q.tb[i].cnt = mmt_pkg::CNT_ALL1;
					bRel[i] = 1'b1;
					next_q.tb[i].first = 1'b0;
					if (!q.tb[i].first && !(st && !q.tb[i].stPrev)) begin
						setB[i] = 1'b1;
					end
				end else if (st && bTk[i]) begin
					if (q.tb[i].cnt == mmt_pkg::CNT_ZERO) begin
						next_q.tb[i].cnt = mmt_pkg::CNT_ALL1;
						next_q.tb[i].mode[mmt_pkg::MODE_OVF] = 1'b1;
						bOvf[i] = 1'b1;
						setB[i] = 1'b1;
						bRel[i] = 1'b1;
					end else begin
						next_q.tb[i].cnt = q.tb[i].cnt - 16'h0001;
					end
				end
			end else if (st && (md == mmt_pkg::BM_EVENT ? edg : bTk[i])) begin
				if (q.tb[i].cnt == mmt_pkg::CNT_ZERO) begin
					next_q.tb[i].cnt = q.tb[i].rld;
					bRel[i] = 1'b1;
					setB[i] = 1'b1;
				end else begin
					next_q.tb[i].cnt = q.tb[i].cnt - 16'h0001;
				end
			end
		end
		// register writes
		if (wrEn) begin
			if (wordAddr == mmt_pkg::OFF_START_A) begin
				wd = merge({24'h0, q.startA}, writedata, byteenable);
				next_q.startA = wd[7:0];
			end
			if (wordAddr == mmt_pkg::OFF_START_B) begin
				wd = merge({24'h0, q.startB}, writedata, byteenable);
				next_q.startB = wd[7:0] & 8'hE0;
			end
			if (wordAddr == mmt_pkg::OFF_THREE_PHASE && byteenable[0]) begin
				next_q.cutoff = writedata[mmt_pkg::CUTOFF_BIT];
			end
			if (wordAddr == mmt_pkg::OFF_IRQ_FLAGS) begin
				old = merge(32'h0000_0000, writedata, byteenable);
				next_q.irA = q.irA & ~old[4:0];
				next_q.irB = q.irB & ~old[mmt_pkg::IRQ_B_LSB +: 6];
			end
			for (int i = 0; i < mmt_pkg::NUM_A; i++) begin
				if (wordAddr == tOff(mmt_pkg::OFF_A_BASE, i, mmt_pkg::SUB_MODE)
					&& byteenable[0]) begin
					wd[7:0] = writedata[7:0];
					next_q.ta[i].mode = wd[7:0];
					if (!q.ta[i].mode[1] && wd[1]) begin
						setA[i] = 1'b1;
					end
				end
				if (wordAddr == tOff(mmt_pkg::OFF_A_BASE, i, mmt_pkg::SUB_COUNT))
					begin
					wd = merge({16'h0, q.ta[i].rld}, writedata, byteenable);
					next_q.ta[i].rld = wd[15:0];
					if (!q.startA[i]) begin
						next_q.ta[i].cnt = wd[15:0];
					end
				end
			end
			for (int i = 0; i < mmt_pkg::NUM_B; i++) begin
				if (wordAddr == tOff(mmt_pkg::OFF_B_BASE, i, mmt_pkg::SUB_MODE)
					&& byteenable[0]) begin
					// overflow bit only clears, and a new overflow wins
					next_q.tb[i].mode = {writedata[7:6],
						(q.tb[i].mode[mmt_pkg::MODE_OVF] & writedata[5])
						| bOvf[i], writedata[4], 1'b0,
						writedata[2:0]};
				end
				if (wordAddr == tOff(mmt_pkg::OFF_B_BASE, i, mmt_pkg::SUB_COUNT))
					begin
					wd = merge({16'h0, q.tb[i].rld}, writedata, byteenable);
					next_q.tb[i].rld = wd[15:0];
					if (!bRun[i]) begin
						next_q.tb[i].cnt = wd[15:0];
					end
				end
			end
		end
		// hardware set wins over software clear
		next_q.irA = next_q.irA | setA;
		next_q.irB = next_q.irB | setB;
		// read mux
		rdVal = 32'h0000_0000;
		rdRel = 1'b0;
		if (wordAddr == mmt_pkg::OFF_START_A) begin
			rdVal = {24'h0, q.startA};
		end
		if (wordAddr == mmt_pkg::OFF_START_B) begin
			rdVal = {24'h0, q.startB};
		end
		if (wordAddr == mmt_pkg::OFF_THREE_PHASE) begin
			rdVal = {31'h0, q.cutoff};
		end
		if (wordAddr == mmt_pkg::OFF_IRQ_FLAGS) begin
			rdVal = {18'h0, q.irB, 3'h0, q.irA};
		end
		for (int i = 0; i < mmt_pkg::NUM_A; i++) begin
			if (wordAddr == tOff(mmt_pkg::OFF_A_BASE, i, mmt_pkg::SUB_MODE)) begin
				rdVal = {24'h0, q.ta[i].mode};
			end
			if (wordAddr == tOff(mmt_pkg::OFF_A_BASE, i, mmt_pkg::SUB_COUNT)) begin
				rdVal = {16'h0, aRel[i] ? (aOvf[i] ? mmt_pkg::CNT_ZERO
					: mmt_pkg::CNT_ALL1) : q.ta[i].cnt};
				rdRel = aRel[i] & ~aOvf[i];
			end
		end
		for (int i = 0; i < mmt_pkg::NUM_B; i++) begin
			if (wordAddr == tOff(mmt_pkg::OFF_B_BASE, i, mmt_pkg::SUB_MODE)) begin
				rdVal = {24'h0, q.tb[i].mode};
			end
			if (wordAddr == tOff(mmt_pkg::OFF_B_BASE, i, mmt_pkg::SUB_COUNT)) begin
				rdVal = {16'h0, bRel[i] ? mmt_pkg::CNT_ALL1
					: q.tb[i].cnt};
				rdRel = bRel[i];
			end
			if (wordAddr == tOff(mmt_pkg::OFF_B_BASE, i, mmt_pkg::SUB_RELOAD)) begin
				rdVal = {16'h0, q.tb[i].rld};
			end
		end
		if (rdEn) begin
			next_q.rdata = rdVal;
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// checks per first-family timer
	for (genvar g = 0; g < mmt_pkg::NUM_A; g++) begin : gChkA
		a_idle_stopped: assert property (@(posedge ref_clk) disable iff (rst)
			(!q.startA[g] && !q.ta[g].stPrev && !write)
			|=> q.ta[g].cnt == $past(q.ta[g].cnt))
			else $error("stopped counter moved");
		a_oneshot_stop: assert property (@(posedge ref_clk) disable iff (rst)
			(q.ta[g].mode[1:0] == 2'h2 && q.ta[g].stPrev && !q.startA[g]
			&& !write) |=> !q.ta[g].out && q.ta[g].cnt == $past(q.ta[g].rld))
			else $error("one-shot stop did not reload and drop output");
		a_stop_ir_late: assert property (@(posedge ref_clk) disable iff (rst)
			(q.ta[g].mode[1:0] == 2'h2 && q.ta[g].stPrev && !q.startA[g])
			|-> ##2 q.irA[g])
			else $error("one-shot stop flag not set two edges later");
		a_pwm_stop_high: assert property (@(posedge ref_clk) disable iff (rst)
			(q.ta[g].mode[1:0] == 2'h3 && q.ta[g].stPrev && !q.startA[g])
			|=> !q.ta[g].out && (q.irA[g] || !$past(q.ta[g].out)))
			else $error("pwm stop handling wrong");
		a_mode_sets_ir: assert property (@(posedge ref_clk) disable iff (rst)
			(!$past(q.ta[g].mode[1]) && q.ta[g].mode[1]) |-> q.irA[g])
			else $error("mode change did not raise request");
		a_retrig_reload: assert property (@(posedge ref_clk) disable iff (rst)
			(q.ta[g].mode[1:0] == 2'h2 && q.startA[g] && q.ta[g].run
			&& q.ta[g].retrig && aTk[g])
			|=> q.ta[g].cnt == $past(q.ta[g].rld))
			else $error("re-trigger did not reload");
	end
	a_cutoff_float: assert property (@(posedge ref_clk) disable iff (rst)
		(q.cutoff && !q.nmiS2) |-> taOutEn[1] == 1'b0 && taOutEn[2] == 1'b0
		&& taOutEn[4] == 1'b0 && taOutEn[0] && taOutEn[3])
		else $error("cutoff did not float outputs");
	a_read_reload: assert property (@(posedge ref_clk) disable iff (rst)
		(rdEn && rdRel) |=> readdata[15:0] == 16'hFFFF)
		else $error("read at reload not all ones");
	// checks per second-family timer
	for (genvar g = 0; g < mmt_pkg::NUM_B; g++) begin : gChkB
		a_meas_ovf: assert property (@(posedge ref_clk) disable iff (rst)
			(q.tb[g].mode[1:0] == 2'h2 && bRun[g] && bTk[g] && !bEff[g]
			&& q.tb[g].cnt == 16'h0000) |=> q.tb[g].mode[5] && q.irB[g])
			else $error("overflow not flagged");
	end
endmodule : mmt_timer_ab

// ==== mmt_pkg.sv ====
// Functional notes
// - timers idle after reset; count only after start bit set to 1
// - first-family timer read coinciding with reload returns FFFFh, except 0000h at event-mode overflow
// - counter written while stopped reads back the written value
// - event mode read at underflow reload gives FFFFh, at overflow 0000h
// - cutoff enable and low nmi pin float outputs of timers 1, 2, 4
// - one-shot stop halts, reloads counter, drives output low
// - one-shot stop sets interrupt request flag one clock later
// - one-shot output and trigger act on count source tick
// - mode change to one-shot from timer or event sets request flag
// - trigger while one-shot runs: count once more, reload, continue
// - mode change to pwm from timer or event sets request flag
// - pwm stop with output high drives low and flags; low: unchanged
// - second-family start bits at bits 5 to 7 of both start registers
// - second-family read coinciding with reload returns FFFFh
// - measurement: flag on effective edge and overflow; overflow bit tells
// - first effective edge after start loads reload, raises no request
// - measurement counter undefined at start; overflow may flag early
// - pulse width results alternate high and low with no level flag
package mmt_pkg;
	localparam int NUM_A = 5;
	localparam int NUM_B = 6;
	localparam int AW = 10;
	// register byte offsets
	localparam logic [9:0] OFF_START_A = 10'h000;
	localparam logic [9:0] OFF_START_B = 10'h004;
	localparam logic [9:0] OFF_THREE_PHASE = 10'h008;
	localparam logic [9:0] OFF_IRQ_FLAGS = 10'h00C;
	localparam logic [9:0] OFF_ONE_SHOT = 10'h010;
	localparam int OFF_A_BASE = 'h040;
	localparam int OFF_B_BASE = 'h100;
	localparam int TMR_STRIDE = 'h010;
	localparam int SUB_MODE = 0;
	localparam int SUB_COUNT = 4;
	localparam int SUB_RELOAD = 8;
	// field positions
	localparam int START_B_LSB = 5;
	localparam int CUTOFF_BIT = 0;
	localparam int IRQ_B_LSB = 8;
	localparam int MODE_OUT_EN = 2;
	localparam int MODE_EXT_TRIG = 2;
	localparam int MODE_WIDTH_SEL = 2;
	localparam int MODE_RESERVED = 3;
	localparam int MODE_UP = 4;
	localparam int MODE_OVF = 5;
	// first family operating modes
	localparam logic [1:0] AM_TIMER = 2'h0;
	localparam logic [1:0] AM_EVENT = 2'h1;
	localparam logic [1:0] AM_ONESHOT = 2'h2;
	localparam logic [1:0] AM_PWM = 2'h3;
	// second family operating modes
	localparam logic [1:0] BM_TIMER = 2'h0;
	localparam logic [1:0] BM_EVENT = 2'h1;
	localparam logic [1:0] BM_MEASURE = 2'h2;
	// reset values and special readbacks
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] CNT_ALL1 = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;

	typedef struct packed {
		logic [7:0] mode;
		logic [15:0] cnt;
		logic [15:0] rld;
		logic out;
		logic run;
		logic trig;
		logic retrig;
		logic stopIr;
		logic stPrev;
		logic inS1;
		logic inS2;
		logic inPrev;
	} mmt_ta_t;

	typedef struct packed {
		logic [7:0] mode;
		logic [15:0] cnt;
		logic [15:0] rld;
		logic first;
		logic stPrev;
		logic inS1;
		logic inS2;
		logic inPrev;
	} mmt_tb_t;

	typedef struct packed {
		mmt_ta_t [NUM_A-1:0] ta;
		mmt_tb_t [NUM_B-1:0] tb;
		logic [7:0] startA;
		logic [7:0] startB;
		logic cutoff;
		logic [NUM_A-1:0] irA;
		logic [NUM_B-1:0] irB;
		logic nmiS1;
		logic nmiS2;
		logic [5:0] pre;
		logic ack;
		logic [31:0] rdata;
	} mmt_state_t;
endpackage : mmt_pkg

// ==== mmt_pin_model.sv ====
`timescale 1ns/1ps
// pin side: nmi pin, trigger inputs and measured pulse source
module mmt_pin_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic nmiLow,
	input wire logic [5:0] pulseEn,
	output logic nmiN,
	output logic [4:0] taIn,
	output logic [5:0] tbIn
);
	logic [3:0] phase;
	// free phase counter for an 8-high, 8-low pulse
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			phase <= 4'h0;
		end else begin
			phase <= phase + 4'h1;
		end
	end
	// nmi pin has a pull-up, so released means high
	assign nmiN = !nmiLow;
	// no external triggers, so none can come too close
	assign taIn = 5'h00;
	// each level lasts 8 cycles, above the synchroniser need
	assign tbIn = pulseEn & {6{phase[3]}};
endmodule : mmt_pin_model

// ==== mmt_timer_ab_tb.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	checkCount++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("mismatch at %0t: got %h expected %h", $time, got, exp); \
	end \
end
module mmt_timer_ab_tb;
	logic ref_clk = 1'b0;
	logic rst;
	logic [9:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [3:0] byteenable;
	logic [31:0] readdata;
	logic waitrequest;
	logic nmiN;
	logic [4:0] taIn;
	logic [5:0] tbIn;
	logic [4:0] taOut;
	logic [4:0] taOutEn;
	logic nmiLow;
	logic [5:0] pulseEn;
	logic [31:0] rd;
	int miscompares;
	int checkCount;
	int cycles;

	mmt_timer_ab i_dut (.ref_clk(ref_clk), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .nmiN(nmiN), .taIn(taIn), .tbIn(tbIn),
		.taOut(taOut), .taOutEn(taOutEn));
	mmt_pin_model i_pins (.ref_clk(ref_clk), .rst(rst), .nmiLow(nmiLow),
		.pulseEn(pulseEn), .nmiN(nmiN), .taIn(taIn), .tbIn(tbIn));

	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;

	// cut a hang short
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			print_verdict();
		end
	end

	task print_verdict;
		if (miscompares == 0 && checkCount > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	// one bus cycle, held until waitrequest is seen low
	task automatic busXfer(input logic [9:0] a, input logic wr,
		input logic [31:0] d);
		int n;
		n = 0;
		address <= a;
		writedata <= d;
		byteenable <= 4'hF;
		read <= !wr;
		write <= wr;
		do begin
			@(posedge ref_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 100);
		if (n >= 100) begin
			miscompares++;
		end
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge ref_clk);
	endtask : busXfer

	task automatic busWr(input logic [9:0] a, input logic [31:0] d);
		busXfer(a, 1'b1, d);
	endtask : busWr

	task automatic busRd(input logic [9:0] a);
		busXfer(a, 1'b0, 32'h0000_0000);
	endtask : busRd

	// wait for a first-family output level, bounded
	task automatic waitOut(input int i, input logic lvl);
		int n;
		n = 0;
		while (taOut[i] !== lvl && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 200) begin
			miscompares++;
		end
	endtask : waitOut

	// idle after reset: nothing started, counter does not move
	task chkReset;
		busRd(10'h000);
		`CHK(rd, 32'h0000_0000)
		repeat (20) @(posedge ref_clk);
		busRd(10'h044);
		`CHK(rd[15:0], 16'h0000)
	endtask : chkReset

	// stopped counters read back what was written
	task chkReadBack;
		busWr(10'h064, 32'h0000_A5C3);
		busRd(10'h064);
		`CHK(rd[15:0], 16'hA5C3)
		busWr(10'h144, 32'h0000_5A3C);
		busRd(10'h144);
		`CHK(rd[15:0], 16'h5A3C)
	endtask : chkReadBack

	// second-family start bits sit at 7:5 of both start registers
	task chkStartB;
		busWr(10'h104, 32'h0000_0400);
		busWr(10'h134, 32'h0000_0400);
		busWr(10'h000, 32'h0000_0020);
		repeat (10) @(posedge ref_clk);
		busRd(10'h104);
		`CHK(rd[15:0] != 16'h0400, 1'b1)
		busRd(10'h134);
		`CHK(rd[15:0], 16'h0400)
		busWr(10'h004, 32'h0000_0020);
		busRd(10'h004);
		`CHK(rd, 32'h0000_0020)
		busRd(10'h134);
		`CHK(rd[15:0] < 16'h0400, 1'b1)
		busWr(10'h000, 32'h0000_0000);
		busWr(10'h004, 32'h0000_0000);
	endtask : chkStartB

	// zero reload makes every tick a reload, so reads give all ones
	task chkReload;
		busWr(10'h000, 32'h0000_0090);
		busRd(10'h084);
		`CHK(rd[15:0], 16'hFFFF)
		busRd(10'h124);
		`CHK(rd[15:0], 16'hFFFF)
		busWr(10'h000, 32'h0000_0000);
	endtask : chkReload

	// entering one-shot or pwm from timer or event mode raises the flag
	task chkModeFlags;
		busWr(10'h00C, 32'h0000_3F1F);
		busWr(10'h040, 32'h0000_0002);
		busWr(10'h050, 32'h0000_0003);
		busWr(10'h060, 32'h0000_0001);
		busWr(10'h060, 32'h0000_0003);
		busWr(10'h070, 32'h0000_0001);
		busWr(10'h070, 32'h0000_0002);
		busWr(10'h080, 32'h0000_0001);
		busRd(10'h00C);
		`CHK(rd[4:0], 5'h0F)
		busWr(10'h00C, 32'h0000_001F);
	endtask : chkModeFlags

	// software stop of a running one-shot
	task chkOneShot;
		busWr(10'h044, 32'h0000_0100);
		busWr(10'h000, 32'h0000_0001);
		busWr(10'h010, 32'h0000_0001);
		repeat (10) @(posedge ref_clk);
		`CHK(taOut[0], 1'b1)
		// second trigger while running restarts the count
		busWr(10'h010, 32'h0000_0001);
		busRd(10'h044);
		`CHK(rd[15:0] > 16'h00F8, 1'b1)
		busWr(10'h00C, 32'h0000_0001);
		busWr(10'h000, 32'h0000_0000);
		`CHK(taOut[0], 1'b0)
		busRd(10'h044);
		`CHK(rd[15:0], 16'h0100)
		busRd(10'h00C);
		`CHK(rd[0], 1'b1)
	endtask : chkOneShot

	// pwm stop with output high, then with output low
	task chkPwmStop;
		int k;
		busWr(10'h054, 32'h0000_0010);
		for (k = 0; k < 2; k++) begin
			busWr(10'h000, 32'h0000_0002);
			waitOut(1, 1'b1);
			if (k == 1) begin
				waitOut(1, 1'b0);
			end
			busWr(10'h00C, 32'h0000_0002);
			busWr(10'h000, 32'h0000_0000);
			`CHK(taOut[1], 1'b0)
			busRd(10'h00C);
			`CHK(rd[1], (k == 0))
		end
	endtask : chkPwmStop

	// outputs 1, 2 and 4 float only with cutoff enabled and nmi low
	task chkCutoff;
		nmiLow <= 1'b1;
		repeat (6) @(posedge ref_clk);
		`CHK(taOutEn, 5'h1F)
		busWr(10'h008, 32'h0000_0001);
		repeat (6) @(posedge ref_clk);
		`CHK(taOutEn, 5'h09)
		nmiLow <= 1'b0;
		repeat (6) @(posedge ref_clk);
		`CHK(taOutEn, 5'h1F)
		busWr(10'h008, 32'h0000_0000);
	endtask : chkCutoff

	// period measurement flags each effective edge, overflow bit clear
	task chkMeasure;
		busWr(10'h110, 32'h0000_0002);
		busWr(10'h00C, 32'h0000_3F00);
		pulseEn <= 6'h02;
		busWr(10'h000, 32'h0000_0040);
		repeat (80) @(posedge ref_clk);
		busWr(10'h110, 32'h0000_0002);
		busWr(10'h00C, 32'h0000_0200);
		repeat (40) @(posedge ref_clk);
		busRd(10'h00C);
		`CHK(rd[9], 1'b1)
		busRd(10'h110);
		`CHK(rd[5], 1'b0)
		`CHK(rd[3], 1'b0)
		busWr(10'h000, 32'h0000_0000);
		pulseEn <= 6'h00;
	endtask : chkMeasure

	// main sequence
	initial begin
		rst = 1'b1;
		address = 10'h000;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0000_0000;
		byteenable = 4'h0;
		nmiLow = 1'b0;
		pulseEn = 6'h00;
		miscompares = 0;
		checkCount = 0;
		cycles = 0;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chkReset();
		chkReadBack();
		chkStartB();
		chkReload();
		chkModeFlags();
		chkOneShot();
		chkPwmStop();
		chkCutoff();
		chkMeasure();
		print_verdict();
	end
endmodule : mmt_timer_ab_tb
